// >>> verilog/iprt_pkg.sv
// package of constants and types for the interrupt priority register block
package iprt_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] IPRT_PRIO_TWO_OFF = 4'h0;   // interrupt_priority_two
   localparam logic [3:0] IPRT_STATUS_OFF = 4'h4;     // source enables, read only
   localparam int IPRT_ADDR_W = 4;
   // field positions (low bit of each 3-bit field)
   localparam int IPRT_SER_RX_LSB = 12;
   localparam int IPRT_SPI_EV_LSB = 8;
   localparam int IPRT_SPI_FLT_LSB = 4;
   localparam int IPRT_TMR3_LSB = 0;
   // writable bits; 15, 11, 7 and 3 are unused
   localparam logic [15:0] IPRT_RW_MASK = 16'h7777;
   // every field resets to level 4
   localparam logic [2:0] IPRT_FIELD_RST = 3'h4;
   localparam logic [15:0] IPRT_PRIO_RST = 16'h4444;
   localparam logic [2:0] IPRT_DISABLED = 3'h0;
   // ****************************************
   // types
   // ****************************************
   localparam logic [1:0] IPRT_RESP_OKAY = 2'h0;
   localparam logic [1:0] IPRT_RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic [2:0] serial_one_receive_priority;
      logic [2:0] spi_one_event_priority;
      logic [2:0] spi_one_fault_priority;
      logic [2:0] timer_three_priority;
   } iprt_levels_t;
   typedef struct packed {
      logic serial_one_receive;
      logic spi_one_event;
      logic spi_one_fault;
      logic timer_three;
   } iprt_enables_t;
endpackage

// >>> verilog/iprt_top.sv
// interrupt priority register two with an axi4-lite slave port
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module iprt_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [iprt_pkg::IPRT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [iprt_pkg::IPRT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // decoded priorities for the arbiter
   output iprt_pkg::iprt_levels_t prio_levels,
   output iprt_pkg::iprt_enables_t prio_enables
);
   import iprt_pkg::*;

   // ****************************************
   // functions
   // ****************************************
   // a field presents its source only when nonzero
   function automatic logic field_enabled(input logic [2:0] lvl);
      return lvl != IPRT_DISABLED;
   endfunction

   // ****************************************
   // write channel
   // ****************************************
   logic [15:0] prio_reg;
   logic [15:0] prio_next;
   logic aw_held_reg;
   logic [IPRT_ADDR_W-1:0] aw_addr_reg;
   logic w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   wire wr_hit = (aw_addr_reg == IPRT_PRIO_TWO_OFF);
   wire [15:0] byte_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire [15:0] wr_mask = byte_mask & IPRT_RW_MASK;

   // merge written bytes into the writable bits only
   assign prio_next = (do_write && wr_hit) ?
                      ((prio_reg & ~wr_mask) | (w_data_reg[15:0] & wr_mask)) : prio_reg;
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready = !w_held_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // hold address and data until both present
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && !aw_held_reg) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (s_axi_wvalid && !w_held_reg) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   // priority register and write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prio_reg <= IPRT_PRIO_RST;
         bvalid_reg <= 1'b0;
         bresp_reg <= IPRT_RESP_OKAY;
      end else begin
         prio_reg <= prio_next;
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_hit || aw_addr_reg == IPRT_STATUS_OFF) ?
                         IPRT_RESP_OKAY : IPRT_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // write channel checks
   // ****************************************
   // both halves held and the response slot free
   sequence s_write_pair;
      aw_held_reg && w_held_reg && !bvalid_reg;
   endsequence
   // response raised and both channels open again
   sequence s_write_answer;
      s_axi_bvalid && s_axi_awready && s_axi_wready;
   endsequence
   // reset seen low on one edge and released on the next
   sequence s_reset_release;
      !aresetn ##1 aresetn;
   endsequence

   // a completed pair answers on the very next edge
   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_write_pair |=> s_write_answer)
      else $error("write response late");
   // mapped offsets answer okay
   a_write_resp_okay: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && (wr_hit || aw_addr_reg == IPRT_STATUS_OFF)
      |=> s_axi_bresp == IPRT_RESP_OKAY)
      else $error("mapped write not okay");
   // any other offset is refused with a slave error
   a_write_resp_error: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && !wr_hit && aw_addr_reg != IPRT_STATUS_OFF
      |=> s_axi_bresp == IPRT_RESP_SLVERR)
      else $error("unmapped write not refused");
   // only a write to the register may change it
   a_no_write_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      !(do_write && wr_hit) |=> $stable(prio_reg))
      else $error("register changed without write");
   // unused positions never hold a one
   a_unused_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (prio_reg & ~IPRT_RW_MASK) == 16'h0000)
      else $error("unused priority bit set");
   // upper lane carries the event and serial fields
   a_spi_event_field: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && wr_hit && w_strb_reg[1]
      |=> prio_levels.spi_one_event_priority == $past(w_data_reg[10:8]))
      else $error("spi event field not written");
   // serial field sits above the event field
   a_serial_field: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && wr_hit && w_strb_reg[1]
      |=> prio_levels.serial_one_receive_priority == $past(w_data_reg[14:12]))
      else $error("serial field not written");
   // a lane left out of the strobes keeps its bits
   a_upper_lane_kept: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && wr_hit && !w_strb_reg[1] |=> $stable(prio_reg[15:8]))
      else $error("upper lane changed");
   // lower lane carries the fault and timer fields
   a_timer_field: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && wr_hit && w_strb_reg[0]
      |=> prio_levels.timer_three_priority == $past(w_data_reg[2:0]))
      else $error("timer three field not written");
   // fault field sits above the timer field
   a_fault_field: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && wr_hit && w_strb_reg[0]
      |=> prio_levels.spi_one_fault_priority == $past(w_data_reg[6:4]))
      else $error("fault field not written");
   a_lower_lane_kept: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && wr_hit && !w_strb_reg[0] |=> $stable(prio_reg[7:0]))
      else $error("lower lane changed");
   // every field comes out of reset at level 4
   a_reset_level_four: assert property (@(posedge aclk)
      s_reset_release |-> prio_reg == IPRT_PRIO_RST)
      else $error("reset value not level 4");
   // after reset every channel is open and no answer pends
   a_reset_idle: assert property (@(posedge aclk)
      s_reset_release |-> s_axi_awready && s_axi_wready && s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid)
      else $error("bus not idle after reset");

   // ****************************************
   // field decode
   // ****************************************
   assign prio_levels.serial_one_receive_priority = prio_reg[IPRT_SER_RX_LSB +: 3];
   assign prio_levels.spi_one_event_priority = prio_reg[IPRT_SPI_EV_LSB +: 3];
   assign prio_levels.spi_one_fault_priority = prio_reg[IPRT_SPI_FLT_LSB +: 3];
   assign prio_levels.timer_three_priority = prio_reg[IPRT_TMR3_LSB +: 3];
   assign prio_enables.serial_one_receive = field_enabled(prio_levels.serial_one_receive_priority);
   assign prio_enables.spi_one_event = field_enabled(prio_levels.spi_one_event_priority);
   assign prio_enables.spi_one_fault = field_enabled(prio_levels.spi_one_fault_priority);
   assign prio_enables.timer_three = field_enabled(prio_levels.timer_three_priority);

   // each level is the plain binary value of its field
   a_level_binary: assert property (@(posedge aclk) disable iff (!aresetn)
      prio_levels.timer_three_priority == prio_reg[2:0]
      && prio_levels.spi_one_fault_priority == prio_reg[6:4]
      && prio_levels.spi_one_event_priority == prio_reg[10:8]
      && prio_levels.serial_one_receive_priority == prio_reg[14:12])
      else $error("level decode wrong");
   // a zero field withholds its source
   a_zero_disables: assert property (@(posedge aclk) disable iff (!aresetn)
      prio_enables.timer_three == (prio_reg[2:0] != 3'h0)
      && prio_enables.spi_one_fault == (prio_reg[6:4] != 3'h0)
      && prio_enables.spi_one_event == (prio_reg[10:8] != 3'h0)
      && prio_enables.serial_one_receive == (prio_reg[14:12] != 3'h0))
      else $error("disable decode wrong");
   // level 4 after reset leaves every source presented
   a_reset_enabled: assert property (@(posedge aclk)
      s_reset_release |-> prio_enables == 4'hF)
      else $error("source disabled after reset");

   // ****************************************
   // read channel
   // ****************************************
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   wire rd_take = s_axi_arvalid && !rvalid_reg;
   wire rd_prio = (s_axi_araddr == IPRT_PRIO_TWO_OFF);
   wire rd_stat = (s_axi_araddr == IPRT_STATUS_OFF);
   wire [31:0] prio_word = {16'h0000, prio_reg & IPRT_RW_MASK};
   wire [31:0] stat_word = {28'h0000000, prio_enables};
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // one read in flight; answer the cycle after address taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= IPRT_RESP_OKAY;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         if (rd_prio) begin
            rdata_reg <= prio_word;
            rresp_reg <= IPRT_RESP_OKAY;
         end else if (rd_stat) begin
            rdata_reg <= stat_word;
            rresp_reg <= IPRT_RESP_OKAY;
         end else begin
            rdata_reg <= '0;
            rresp_reg <= IPRT_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ****************************************
   // read channel checks
   // ****************************************
   // an address taken while no answer is pending
   sequence s_read_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // answer raised and the address channel closed
   sequence s_read_answer;
      s_axi_rvalid && !s_axi_arready;
   endsequence

   // a taken address answers on the very next edge
   a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_read_take |=> s_read_answer)
      else $error("read answer late");
   // register reads show the writable bits only
   a_prio_read_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && rd_prio |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000
      && s_axi_rdata[15] == 1'b0 && s_axi_rdata[11] == 1'b0
      && s_axi_rdata[7] == 1'b0 && s_axi_rdata[3] == 1'b0)
      else $error("unused bit read nonzero");
   // register reads return the fields as they stand
   a_prio_read_value: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && rd_prio |=> s_axi_rdata[15:0] == ($past(prio_reg) & IPRT_RW_MASK))
      else $error("register read wrong");
   // status reads show which sources are presented
   a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && rd_stat |=> s_axi_rdata == {28'h0000000, $past(prio_enables)})
      else $error("status word wrong");
   // mapped offsets answer okay
   a_read_okay: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && (rd_prio || rd_stat) |=> s_axi_rresp == IPRT_RESP_OKAY)
      else $error("mapped read not okay");
   // unmapped reads return zero with a slave error
   a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && !rd_prio && !rd_stat
      |=> s_axi_rresp == IPRT_RESP_SLVERR && s_axi_rdata == 32'h00000000)
      else $error("unmapped read not refused");
endmodule // iprt_top

// >>> testbench/iprt_top_test.sv
// self-checking bench for the interrupt priority register block
`timescale 1ns/10ps
module iprt_top_test;
   import iprt_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
   logic [31:0] wdata = 0, rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   iprt_levels_t levels;
   iprt_enables_t enables;
   logic [33:0] rq[$], bq[$];
   logic [15:0] exp_reg;
   int n_errors = 0, checked = 0, cycles = 0, k;
   logic [31:0] seed = 32'h0000003C;
   iprt_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .prio_levels(levels), .prio_enables(enables));
   // ****************************************
   // clock, timeout and helpers
   // ****************************************
   always #50 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         complete_run();
      end
   end
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [3:0] enab(input logic [15:0] r);
      return {|r[14:12], |r[10:8], |r[6:4], |r[2:0]};
   endfunction
   task automatic check_v(input string name, input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %0s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************************************
   // monitor: oldest note against each answer
   // ****************************************
   always @(negedge aclk) begin
      if (bvalid && bready) check_v("bresp", {32'h0, bresp}, bq.pop_front());
      if (rvalid && rready) check_v("rdata", {rresp, rdata}, rq.pop_front());
   end
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 0;
      w_done = 0;
      bq.push_back({32'h0, r});
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1;
      while (!(aw_done && w_done)) begin
         @(negedge aclk);
         if (awvalid && awready) aw_done = 1;
         if (wvalid && wready) w_done = 1;
         @(posedge aclk);
         if (aw_done) awvalid <= 0;
         if (w_done) wvalid <= 0;
      end
      while (bq.size() != 0) @(posedge aclk);
   endtask
   task automatic axi_read(input logic [3:0] a, input logic [33:0] e);
      logic done;
      done = 0;
      rq.push_back(e);
      @(posedge aclk);
      araddr <= a; arvalid <= 1;
      while (!done) begin
         @(negedge aclk);
         done = arvalid && arready;
         @(posedge aclk);
         if (done) arvalid <= 0;
      end
      while (rq.size() != 0) @(posedge aclk);
   endtask
   // register write with the model kept alongside, then full readback of outputs
   task automatic put_reg(input logic [31:0] d, input logic [3:0] s);
      logic [33:0] exp_lv;
      axi_write(IPRT_PRIO_TWO_OFF, d, s, IPRT_RESP_OKAY);
      if (s[0]) exp_reg[7:0] = d[7:0] & 8'h77;
      if (s[1]) exp_reg[15:8] = d[15:8] & 8'h77;
      exp_lv = {22'h0, exp_reg[14:12], exp_reg[10:8], exp_reg[6:4], exp_reg[2:0]};
      @(negedge aclk);
      check_v("levels", {22'h0, levels}, exp_lv);
      check_v("enables", {30'h0, enables}, {30'h0, enab(exp_reg)});
      axi_read(IPRT_PRIO_TWO_OFF, {2'h0, 16'h0, exp_reg});
      axi_read(IPRT_STATUS_OFF, {2'h0, 28'h0, enab(exp_reg)});
   endtask
   task automatic do_reset();
      aresetn <= 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      bready <= 1;
      rready <= 1;
      exp_reg = 16'h4444;
      @(negedge aclk);
      check_v("ready", {31'h0, awready, wready, arready}, {31'h0, 3'h7});
      put_reg(32'h0, 4'h0);
      $display("test reset done");
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      do_reset();
      // every code in every field, unused and upper bits set
      for (k = 0; k < 8; k++) put_reg(32'hFFFF8888 | (k * 32'h1111), 4'hF);
      $display("test levels done");
      for (k = 0; k < 20; k++) begin
         seed = xorshift(seed);
         put_reg(seed, seed[19:16]);
      end
      $display("test random done");
      axi_write(IPRT_STATUS_OFF, 32'h0, 4'hF, IPRT_RESP_OKAY);
      axi_write(4'h8, 32'h0, 4'hF, IPRT_RESP_SLVERR);
      axi_read(4'hC, {IPRT_RESP_SLVERR, 32'h0});
      put_reg(32'h0, 4'h0);
      $display("test refused done");
      do_reset();
      complete_run();
   end
endmodule // iprt_top_test
